// ===== rtl/bus_frame_scheduler.sv
// Purpose: Bus controller medium redundancy and cyclic frame schedule
// Assumes: Bus interface logic on mclk_in; second tick from central time
// Notes: Slot 24 absorbs the remainder of each subframe
//
// Overview of operation
// [RULE1] After reset all traffic uses medium A.
// [RULE2] Isolated failure of A moves all traffic globally to medium B.
// [RULE3] Never return automatically from B to A; B failures cause no recovery.
// [RULE4] Selected medium is readable as status.
// [RULE5] Probe B while traffic stays on A; confirm when B good, A failed.
// [RULE6] Triggers: terminal timeout, terminal transmit error, loop-back failure.
// [RULE7] Commands: select A, select B, disable and enable auto switching.
// [RULE8] Detected bus errors reported on a dedicated fault interface.
// [RULE9] One second frame of 64 equal subframes aligned to central time.
// [RULE10] Each subframe is a fixed sequence of 24 message slots.
// [RULE11] Subframe 0 slot 1 carries sync mode command without data word.
// [RULE12] No telemetry in subframe 0; telecommands only.
// [RULE13] Other subframes slot 1 carries sync with data word.
// [RULE14] Counts 0, 16, 32, 48 reserved for telecommand transfer.
// [RULE15] Time information distributed in subframe count 32.
// [RULE16] Remaining subframes carry telemetry, telecommand also allowed.
// [RULE17] Subframe count runs 0 to 63, one less than ordinal.
// [RULE18] A telemetry packet never crosses a subframe boundary.
// [RULE19] Telemetry up to 1024 octets, telecommand up to 248 octets.
// [RULE20] At least 2.5 ms between transfers of one type per terminal.
// [RULE21] Schedule allows 50 telemetry, 16 telecommand, time, two short TCs.
// [RULE22] Short asynchronous telecommand delivered within one millisecond.
// [RULE23] Sync: address 11111, T 1, subaddress 0, mode 00001 or R 10001.
// [RULE24] Sync data word: 5-bit sender, 6 reserved bits, 5-bit count.
// [RULE25] Sender field holds allocated terminal or zero.
// [RULE26] Slot lengths 150, 750 x19, 150 x3, last at most 775 us.
// [RULE27] With auto switching off, errors still reported, medium unchanged.
// [RULE28] Subframe count resets to zero on each one-second tick.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module bus_frame_scheduler
	import bus_sched_pkg::*;
#(
	parameter int SHORT_CYC = SLOT_SHORT_CYC,
	parameter int LONG_CYC = SLOT_LONG_CYC,
	parameter int SF_CYC = SUBFRAME_CYC,
	parameter int GAP_CYCLES = GAP_CYC
)
(
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic second_tick_in,
	input wire logic rt_timeout_in,
	input wire logic rt_tx_error_in,
	input wire logic loopback_fail_in,
	input wire logic probe_done_in,
	input wire logic probe_ok_in,
	input wire logic tm_done_in,
	input wire logic tc_done_in,
	input wire logic async_tc_req_in,
	output logic medium_b_out,
	output logic probe_req_out,
	output logic fault_valid_out,
	output logic [2:0] fault_code_out,
	output logic slot_start_out,
	output logic [5:0] subframe_count_out,
	output logic [4:0] slot_index_out,
	output logic sync_valid_out,
	output logic [15:0] sync_cmd_out,
	output logic sync_data_valid_out,
	output logic [15:0] sync_data_out,
	output logic time_dist_out,
	output logic tm_permit_out,
	output logic tc_permit_out,
	output logic async_tc_grant_out
);
	function automatic logic tc_reserved(input logic [5:0] sf);
		return sf[3:0] == 4'h0;
	endfunction

	function automatic logic pkt_slot(input logic [4:0] s);
		return s >= SLOT_FIRST_PKT && s <= SLOT_LAST_PKT;
	endfunction

	logic sec_s1_q, sec_s2_q, sec_s3_q, sec_tick;
	logic [31:0] sf_cyc_q, slot_cyc_q, tm_gap_q, tc_gap_q;
	logic [5:0] sf_q;
	logic [4:0] slot_q;
	logic sf_start, slot_end;
	logic medium_b_q, auto_en_q;
	iso_state_t iso_q;
	logic [4:0] alloc_mem [SUBFRAMES];
	logic [2:0] err_q;
	logic async_pend_q;
	logic wait_q;
	logic [31:0] rdata_d;
	logic [2:0] trig;
	logic bus_wr, cmd_wr;

	// Second tick is asynchronous to this clock
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			sec_s1_q <= 1'b0;
			sec_s2_q <= 1'b0;
			sec_s3_q <= 1'b0;
		end
		else
		begin
			sec_s1_q <= second_tick_in;
			sec_s2_q <= sec_s1_q;
			sec_s3_q <= sec_s2_q;
		end
	end
	assign sec_tick = sec_s2_q && !sec_s3_q;

	// [RULE9] equal subframes from tick
	assign sf_start = sec_tick || sf_cyc_q == 32'(SF_CYC - 1);
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			sf_cyc_q <= '0;
		else if (sf_start)
			sf_cyc_q <= '0;
		else
			sf_cyc_q <= sf_cyc_q + 32'h1;
	end

	// [RULE28] count restarts on tick
	// [RULE17] count 0 to 63
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			sf_q <= '0;
		else if (sec_tick)
			sf_q <= '0;
		else if (sf_start)
			sf_q <= sf_q + 6'h1;
	end

	// [RULE26] slot lengths; last slot takes the remainder
	assign slot_end = slot_q != SLOT_LAST && slot_cyc_q == ((slot_q
		>= SLOT_FIRST_LONG && slot_q <= SLOT_LAST_PKT) ?
		32'(LONG_CYC - 1) : 32'(SHORT_CYC - 1));
	// [RULE10] fixed 24-slot sequence
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			slot_q <= '0;
			slot_cyc_q <= '0;
		end
		else if (sf_start)
		begin
			slot_q <= '0;
			slot_cyc_q <= '0;
		end
		else if (slot_end)
		begin
			slot_q <= slot_q + 5'h1;
			slot_cyc_q <= '0;
		end
		else if (slot_q != SLOT_LAST)
			slot_cyc_q <= slot_cyc_q + 32'h1;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			slot_start_out <= 1'b0;
			subframe_count_out <= '0;
			slot_index_out <= '0;
		end
		else
		begin
			slot_start_out <= sf_start || slot_end;
			subframe_count_out <= sf_start ? (sec_tick ? 6'h0 : sf_q + 6'h1)
				: sf_q;
			slot_index_out <= sf_start ? 5'h0 : (slot_end ? slot_q + 5'h1
				: slot_q);
		end
	end

	// Sync words issued in slot 1 of each subframe
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			sync_valid_out <= 1'b0;
			sync_cmd_out <= '0;
			sync_data_valid_out <= 1'b0;
			sync_data_out <= '0;
		end
		else
		begin
			sync_valid_out <= sf_start;
			sync_data_valid_out <= 1'b0;
			if (sf_start && (sec_tick || sf_q == SF_LAST))
			begin
				// [RULE11] plain sync first subframe
				// [RULE23] transmit bit set
				sync_cmd_out <= {BCAST_ADDR, 1'b1, MODE_SUBADDR, MODE_SYNC};
			end
			else if (sf_start)
			begin
				// [RULE13] sync with data word
				sync_cmd_out <= {BCAST_ADDR, 1'b0, MODE_SUBADDR,
					MODE_SYNC_DATA};
				sync_data_valid_out <= 1'b1;
				// [RULE24] sender, reserved, count
				// [RULE25] zero when unallocated
				sync_data_out <= {alloc_mem[sf_q + 6'h1], SYNC_RESERVED,
					sf_q[4:0] + 5'h1};
			end
		end
	end

	// [RULE20] spacing per transfer type
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			tm_gap_q <= '0;
			tc_gap_q <= '0;
		end
		else
		begin
			if (tm_done_in)
				tm_gap_q <= 32'(GAP_CYCLES);
			else if (tm_gap_q != '0)
				tm_gap_q <= tm_gap_q - 32'h1;
			if (tc_done_in)
				tc_gap_q <= 32'(GAP_CYCLES);
			else if (tc_gap_q != '0)
				tc_gap_q <= tc_gap_q - 32'h1;
		end
	end

	// Packet windows; [RULE18] window closes before subframe end
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			tm_permit_out <= 1'b0;
			tc_permit_out <= 1'b0;
			time_dist_out <= 1'b0;
		end
		else
		begin
			// [RULE12] no telemetry in reserved subframes
			// [RULE16] telemetry elsewhere when allocated
			tm_permit_out <= !sf_start && pkt_slot(slot_q) &&
				!tc_reserved(sf_q) && alloc_mem[sf_q] != 5'h0 &&
				tm_gap_q == '0 && !tm_done_in;
			// [RULE14] telecommands in every subframe
			tc_permit_out <= !sf_start && pkt_slot(slot_q) &&
				tc_gap_q == '0 && !tc_done_in;
			// [RULE15] time distribution subframe
			time_dist_out <= !sf_start && sf_q == SF_TIME &&
				slot_q == SLOT_FIRST_LONG;
		end
	end

	// [RULE22] grant at next non-sync slot start, within the last slot plus slot 0
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			async_pend_q <= 1'b0;
			async_tc_grant_out <= 1'b0;
		end
		else
		begin
			async_tc_grant_out <= slot_end && async_pend_q;
			if (async_tc_req_in)
				async_pend_q <= 1'b1;
			else if (slot_end)
				async_pend_q <= 1'b0;
		end
	end

	// [RULE6] switch-over triggers
	assign trig = {loopback_fail_in, rt_tx_error_in, rt_timeout_in};
	assign bus_wr = avs_write_in && !wait_q;
	assign cmd_wr = bus_wr && avs_address_in == REG_CMD &&
		avs_byteenable_in[0];

	// [RULE8] fault report pulse
	// [RULE27] reported regardless of auto setting
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			fault_valid_out <= 1'b0;
			fault_code_out <= FLT_NONE;
		end
		else
		begin
			fault_valid_out <= trig != 3'h0;
			fault_code_out <= trig;
		end
	end

	// Sticky error bits, set wins over write-one clear
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			err_q <= '0;
		else if (bus_wr && avs_address_in == REG_ERRORS &&
			avs_byteenable_in[0])
			err_q <= (err_q & ~avs_writedata_in[2:0]) | trig;
		else
			err_q <= err_q | trig;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			auto_en_q <= RST_AUTO_EN;
		else if (cmd_wr && avs_writedata_in[CMD_AUTO_ON])
			auto_en_q <= 1'b1;
		else if (cmd_wr && avs_writedata_in[CMD_AUTO_OFF])
			auto_en_q <= 1'b0;
	end

	// [RULE5] probe medium B while A keeps traffic
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			iso_q <= ISO_IDLE;
			probe_req_out <= 1'b0;
		end
		else
		begin
			probe_req_out <= 1'b0;
			case (iso_q)
				ISO_IDLE:
				begin
					if (trig != 3'h0 && !medium_b_q && auto_en_q && !cmd_wr)
					begin
						iso_q <= ISO_PROBE;
						probe_req_out <= 1'b1;
					end
				end
				ISO_PROBE:
				begin
					if (probe_done_in || medium_b_q || !auto_en_q)
						iso_q <= ISO_IDLE;
				end
				default:
					iso_q <= ISO_IDLE;
			endcase
		end
	end

	// [RULE1] medium A after reset
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			medium_b_q <= RST_MEDIUM_B;
		// [RULE7] explicit selects take priority
		else if (cmd_wr && avs_writedata_in[CMD_SEL_B])
			medium_b_q <= 1'b1;
		else if (cmd_wr && avs_writedata_in[CMD_SEL_A])
			medium_b_q <= 1'b0;
		// [RULE2] global switch once confirmed
		// [RULE3] only ever A to B
		else if (iso_q == ISO_PROBE && probe_done_in && probe_ok_in &&
			auto_en_q)
			medium_b_q <= 1'b1;
	end
	assign medium_b_out = medium_b_q;

	// Allocation table: data[5:0] subframe, data[12:8] terminal
	always_ff @(posedge mclk_in)
	begin
		if (bus_wr && avs_address_in == REG_ALLOC && avs_byteenable_in[1])
			alloc_mem[avs_writedata_in[5:0]] <= avs_writedata_in[12:8];
	end

	// Table has no reset; software fills every entry before use
	always_comb
	begin
		rdata_d = '0;
		case (avs_address_in)
			// [RULE4] medium status readable
			REG_STATUS:
				rdata_d = {11'h0, slot_q, 2'h0, sf_q, 5'h0, iso_q == ISO_PROBE,
					auto_en_q, medium_b_q};
			REG_ERRORS:
				rdata_d = {29'h0, err_q};
			REG_ALLOC:
				rdata_d = {27'h0, alloc_mem[sf_q]};
			default:
				rdata_d = '0;
		endcase
	end

	// One wait cycle, then ready for exactly one cycle
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wait_q <= 1'b1;
			avs_readdata_out <= '0;
		end
		else if (wait_q && (avs_read_in || avs_write_in))
		begin
			wait_q <= 1'b0;
			avs_readdata_out <= rdata_d;
		end
		else
			wait_q <= 1'b1;
	end
	assign avs_waitrequest_out = wait_q;

	// [RULE19] size limits are kept by packet descriptors elsewhere
	// [RULE21] 60 telemetry and 64 command subframes exceed minimums

	// Pending age; too long for a delay range in a property
	logic [31:0] async_wait_q;
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			async_wait_q <= '0;
		else if (!async_pend_q || slot_end)
			async_wait_q <= '0;
		else
			async_wait_q <= async_wait_q + 32'h1;
	end

	a_medium_b_sticky: assert property (@(posedge mclk_in) // [RULE3]
		disable iff (sys_rst_in)
		medium_b_q && !cmd_wr |=> medium_b_q)
		else $error("medium left B without command");
	a_switch_confirm: assert property (@(posedge mclk_in) // [RULE5]
		disable iff (sys_rst_in)
		$rose(medium_b_q) && !$past(cmd_wr) |->
		$past(iso_q == ISO_PROBE && probe_ok_in))
		else $error("switch without confirmed probe");
	a_auto_off_hold: assert property (@(posedge mclk_in) // [RULE27]
		disable iff (sys_rst_in)
		!auto_en_q && !cmd_wr && !medium_b_q |=> !medium_b_q)
		else $error("medium changed with auto off");
	a_fault_report: assert property (@(posedge mclk_in) // [RULE8]
		disable iff (sys_rst_in)
		trig != 3'h0 |=> fault_valid_out && fault_code_out == $past(trig))
		else $error("fault not reported");
	a_tm_reserved: assert property (@(posedge mclk_in) // [RULE12]
		disable iff (sys_rst_in)
		tm_permit_out |-> !tc_reserved(subframe_count_out))
		else $error("telemetry in reserved subframe");
	a_sync_plain: assert property (@(posedge mclk_in) // [RULE11]
		disable iff (sys_rst_in)
		sync_valid_out && subframe_count_out == 6'h0 |->
		sync_cmd_out == 16'hfc01 && !sync_data_valid_out)
		else $error("bad plain sync");
	a_sync_data: assert property (@(posedge mclk_in) // [RULE13]
		disable iff (sys_rst_in)
		sync_valid_out && subframe_count_out != 6'h0 |->
		sync_cmd_out == 16'hf811 && sync_data_valid_out &&
		sync_data_out[4:0] == subframe_count_out[4:0])
		else $error("bad sync with data");
	a_slot_short: assert property (@(posedge mclk_in) // [RULE26]
		disable iff (sys_rst_in)
		slot_end && slot_q == 5'h0 |-> slot_cyc_q == 32'(SHORT_CYC - 1))
		else $error("first slot wrong length");
	// Worst case: request at start of slot 23, granted after slot 0
	a_async_grant: assert property (@(posedge mclk_in) // [RULE22]
		disable iff (sys_rst_in)
		async_wait_q < 32'(SF_CYC - 3 * SHORT_CYC - 19 * LONG_CYC + 2))
		else $error("short command not granted in time");
	c_switch_b: cover property (@(posedge mclk_in) $rose(medium_b_q));
	c_probe_fail: cover property (@(posedge mclk_in)
		iso_q == ISO_PROBE && probe_done_in && !probe_ok_in);
	c_tm_window: cover property (@(posedge mclk_in) $rose(tm_permit_out));
	c_time_sf: cover property (@(posedge mclk_in) time_dist_out);
endmodule

// ===== rtl/bus_sched_pkg.sv
// Purpose: Shared constants for the bus frame scheduler
// Assumes: 100 MHz system clock
// Notes: Times kept in microseconds, cycle counts derived from them
package bus_sched_pkg;
	localparam int CLK_MHZ = 100;
	localparam int FRAME_US = 1000000;
	localparam int SUBFRAMES = 64;
	localparam int SLOTS = 24;
	localparam int SLOT_SHORT_US = 150;
	localparam int SLOT_LONG_US = 750;
	localparam int SLOT_REG_MAX_US = 775;
	localparam int TM_GAP_US = 2500;
	localparam int ASYNC_LAT_US = 1000;
	localparam int TM_MAX_OCTETS = 1024;
	localparam int TC_MAX_OCTETS = 248;
	localparam int SHORT_TC_MAX_OCTETS = 64;
	localparam int SLOT_SHORT_CYC = SLOT_SHORT_US * CLK_MHZ;
	localparam int SLOT_LONG_CYC = SLOT_LONG_US * CLK_MHZ;
	localparam int SUBFRAME_CYC = FRAME_US * CLK_MHZ / SUBFRAMES;
	localparam int GAP_CYC = TM_GAP_US * CLK_MHZ;
	// Slot indices are zero based
	localparam logic [4:0] SLOT_FIRST_LONG = 5'h01;
	localparam logic [4:0] SLOT_FIRST_PKT = 5'h04;
	localparam logic [4:0] SLOT_LAST_PKT = 5'h13;
	localparam logic [4:0] SLOT_LAST = 5'h17;
	localparam logic [5:0] SF_TIME = 6'h20;
	localparam logic [5:0] SF_LAST = 6'h3f;
	// Sync mode command fields
	localparam logic [4:0] BCAST_ADDR = 5'h1f;
	localparam logic [4:0] MODE_SUBADDR = 5'h00;
	localparam logic [4:0] MODE_SYNC = 5'h01;
	localparam logic [4:0] MODE_SYNC_DATA = 5'h11;
	localparam logic [5:0] SYNC_RESERVED = 6'h00;
	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ALLOC = 8'h08;
	localparam logic [7:0] REG_ERRORS = 8'h0c;
	// Command bits in REG_CMD
	localparam int CMD_SEL_A = 0;
	localparam int CMD_SEL_B = 1;
	localparam int CMD_AUTO_OFF = 2;
	localparam int CMD_AUTO_ON = 3;
	// Fault codes reported upward
	localparam logic [2:0] FLT_NONE = 3'h0;
	localparam logic [2:0] FLT_TIMEOUT = 3'h1;
	localparam logic [2:0] FLT_TX_ERR = 3'h2;
	localparam logic [2:0] FLT_LOOPBACK = 3'h4;
	localparam logic RST_MEDIUM_B = 1'b0;
	localparam logic RST_AUTO_EN = 1'b1;
	typedef enum logic [1:0] {
		ISO_IDLE = 2'b01,
		ISO_PROBE = 2'b10
	} iso_state_t;
endpackage

// ===== tb/rt_partner.sv
// Purpose: Behavioural remote terminals and medium B probe responder
// Assumes: Same clock as the scheduler
// Notes: Probe result wanders outside the done pulse
`timescale 1ns/1ps
module rt_partner (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic probe_req_in,
	input wire logic answer_ok_in,
	input wire logic [4:0] answer_dly_in,
	input wire logic slot_start_in,
	input wire logic permit_tlm_in,
	input wire logic permit_tcmd_in,
	output logic probe_done_out,
	output logic probe_ok_out,
	output logic done_tlm_out,
	output logic done_tcmd_out
);
	logic [5:0] wait_q;
	logic [6:0] pos_q;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wait_q <= 6'h00;
			probe_done_out <= 1'b0;
			probe_ok_out <= 1'b0;
		end
		else
		begin
			probe_done_out <= (wait_q == 6'h01);
			// Level means nothing without done
			probe_ok_out <= (wait_q == 6'h01) ? answer_ok_in : ~probe_ok_out;
			if (probe_req_in)
				wait_q <= {1'b0, answer_dly_in} + 6'h02;
			else if (wait_q != 6'h00)
				wait_q <= wait_q - 6'h01;
		end
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pos_q <= 7'h00;
			done_tlm_out <= 1'b0;
			done_tcmd_out <= 1'b0;
		end
		else
		begin
			pos_q <= slot_start_in ? 7'h00 : pos_q + 7'h01;
			done_tlm_out <= permit_tlm_in && pos_q == 7'h13;
			done_tcmd_out <= permit_tcmd_in && pos_q == 7'h18;
		end
	end
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the bus frame scheduler
// Assumes: Shortened slot, subframe and gap counts
// Notes: Drivers queue expectations, one monitor compares them
`timescale 1ns/1ps
module tb
	import bus_sched_pkg::*;
;
	localparam int SH = 10;
	localparam int LG = 50;
	localparam int SF = 1200;
	localparam int GP = 100;
	logic mclk_in = 1'b0;
	logic sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [7:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, r;
	logic [3:0] avs_byteenable_in;
	logic second_tick_in, rt_timeout_in, rt_tx_error_in, loopback_fail_in;
	logic probe_done_in, probe_ok_in, tm_done_in, tc_done_in;
	logic async_tc_req_in, medium_b_out, probe_req_out, fault_valid_out;
	logic [2:0] fault_code_out;
	logic slot_start_out, sync_valid_out, sync_data_valid_out, time_dist_out;
	logic [5:0] subframe_count_out, e_sf;
	logic [4:0] slot_index_out, e_slot, answer_dly;
	logic [15:0] sync_cmd_out, sync_data_out;
	logic tm_permit_out, tc_permit_out, async_tc_grant_out, answer_ok;
	logic [31:0] seed = 32'h4ffdf09f;
	logic [4:0] alloc [64];
	logic [63:0] rd_q[$];
	logic [63:0] e;
	logic [15:0] sync_q[$], sdat_q[$];
	logic [2:0] flt_q[$];
	int n_errors = 0, checks = 0, n_probe = 0, cycles = 0, cyc = 0;
	int tlm_gap = GP, tcmd_gap = GP;
	logic armed = 1'b0, first = 1'b0, tlm_ok, tcmd_ok;

	bus_frame_scheduler #(.SHORT_CYC(SH), .LONG_CYC(LG), .SF_CYC(SF),
		.GAP_CYCLES(GP)) uut (
		.mclk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .second_tick_in, .rt_timeout_in, .rt_tx_error_in,
		.loopback_fail_in, .probe_done_in, .probe_ok_in, .tm_done_in,
		.tc_done_in, .async_tc_req_in, .medium_b_out, .probe_req_out,
		.fault_valid_out, .fault_code_out, .slot_start_out, .subframe_count_out,
		.slot_index_out, .sync_valid_out, .sync_cmd_out, .sync_data_valid_out,
		.sync_data_out, .time_dist_out, .tm_permit_out, .tc_permit_out,
		.async_tc_grant_out
	);
	rt_partner terminals (
		.clk_in(mclk_in), .rst_in(sys_rst_in), .probe_req_in(probe_req_out),
		.answer_ok_in(answer_ok), .answer_dly_in(answer_dly),
		.slot_start_in(slot_start_out), .permit_tlm_in(tm_permit_out),
		.permit_tcmd_in(tc_permit_out), .probe_done_out(probe_done_in),
		.probe_ok_out(probe_ok_in), .done_tlm_out(tm_done_in),
		.done_tcmd_out(tc_done_in)
	);

	always #5 mclk_in = ~mclk_in;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int dur(input logic [4:0] s);
		if (s == 5'h00 || (s > 5'h13 && s < 5'h17))
			return SH;
		return (s < 5'h14) ? LG : SF - 4 * SH - 19 * LG;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		@(posedge mclk_in);
		// Only the bench timeout ends a hung wait
		while (avs_waitrequest_out !== 1'b0)
			@(posedge mclk_in);
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		rd_q.push_back({m, x});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic cmd(input logic [3:0] c, input logic m);
		bus(1'b1, REG_CMD, {28'h0, c});
		repeat (2) @(posedge mclk_in);
		chk(medium_b_out, m);
	endtask
	// Settle window covers the longest probe answer
	task automatic fire(input int k);
		flt_q.push_back(3'h1 << k);
		rt_timeout_in <= (k == 0);
		rt_tx_error_in <= (k == 1);
		loopback_fail_in <= (k == 2);
		@(posedge mclk_in);
		rt_timeout_in <= 1'b0;
		rt_tx_error_in <= 1'b0;
		loopback_fail_in <= 1'b0;
		repeat (40) @(posedge mclk_in);
	endtask
	task automatic arm(input int n);
		armed = 1'b0;
		do
			@(posedge mclk_in);
		while (sync_valid_out !== 1'b1);
		second_tick_in <= 1'b1;
		for (int c = 0; c < n; c++)
		begin
			sync_q.push_back(c == 0 ? {5'h1f, 1'b1, 5'h00, 5'h01}
				: {5'h1f, 1'b0, 5'h00, 5'h11});
			if (c > 0)
				sdat_q.push_back({alloc[c], 6'h00, c[4:0]});
		end
		// Arm after this edge so the stale sync pulse is not popped
		@(posedge mclk_in);
		first = 1'b1;
		armed = 1'b1;
		repeat (3) @(posedge mclk_in);
		second_tick_in <= 1'b0;
	endtask
	task automatic grant();
		int k;
		k = 0;
		async_tc_req_in <= 1'b1;
		@(posedge mclk_in);
		async_tc_req_in <= 1'b0;
		do
		begin
			@(posedge mclk_in);
			k++;
		end
		while (async_tc_grant_out !== 1'b1 && k < 2 * LG);
		chk(async_tc_grant_out, 1'b1);
	endtask

	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	always @(posedge mclk_in)
	begin
		tlm_gap++;
		tcmd_gap++;
		if (tm_done_in === 1'b1)
			tlm_gap = 0;
		if (tc_done_in === 1'b1)
			tcmd_gap = 0;
		if (probe_req_out === 1'b1)
			n_probe++;
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
		begin
			e = rd_q.pop_front();
			chk(avs_readdata_out & e[63:32], e[31:0]);
		end
		if (fault_valid_out === 1'b1)
			chk(fault_code_out, flt_q.pop_front());
		if (armed)
		begin
			cyc++;
			if (sync_valid_out === 1'b1)
			begin
				chk(sync_cmd_out, sync_q.pop_front());
				if (first)
				begin
					e_sf = 6'h3f;
					e_slot = 5'h17;
					cyc = dur(e_slot);
					first = 1'b0;
				end
			end
			if (sync_data_valid_out === 1'b1)
				chk(sync_data_out, sdat_q.pop_front());
			if (slot_start_out === 1'b1 && !first)
			begin
				chk(cyc, dur(e_slot));
				e_slot = (e_slot == 5'h17) ? 5'h00 : e_slot + 5'h01;
				if (e_slot == 5'h00)
					e_sf = e_sf + 6'h01;
				cyc = 0;
			end
			// Window reopens two cycles after the gap count runs out
			tcmd_ok = e_slot > 5'h03 && e_slot < 5'h14 && tcmd_gap >= GP + 2;
			tlm_ok = e_slot > 5'h03 && e_slot < 5'h14 && tlm_gap >= GP + 2;
			tlm_ok = tlm_ok && e_sf[3:0] != 4'h0 && alloc[e_sf] != 5'h00;
			if (cyc == 3 && !first)
				chk({subframe_count_out, slot_index_out, time_dist_out,
					tm_permit_out, tc_permit_out}, {e_sf, e_slot,
					e_sf == 6'h20 && e_slot == 5'h01, tlm_ok, tcmd_ok});
		end
	end

	initial
	begin
		sys_rst_in = 1'b1;
		{avs_read_in, avs_write_in, second_tick_in, async_tc_req_in} = 4'h0;
		{rt_timeout_in, rt_tx_error_in, loopback_fail_in, answer_ok} = 4'h0;
		avs_address_in = 8'h00;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		answer_dly = 5'h00;
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		@(posedge mclk_in);
		chk(medium_b_out, 1'b0);
		rd(REG_STATUS, 32'h7, 32'h2);
		bus(1'b1, REG_STATUS, 32'h1);
		bus(1'b1, 8'h10, 32'hf);
		rd(8'h10, 32'hffffffff, 32'h0);
		rd(REG_STATUS, 32'h7, 32'h2);
		for (int i = 0; i < 64; i++)
		begin
			r = xs();
			alloc[i] = r[4:0];
			bus(1'b1, REG_ALLOC, {19'h0, alloc[i], 2'h0, i[5:0]});
		end
		r = xs();
		answer_dly <= r[4:0];
		fire(0);
		chk(medium_b_out, 1'b0);
		chk(n_probe, 1);
		answer_ok <= 1'b1;
		fire(1);
		chk(medium_b_out, 1'b1);
		rd(REG_STATUS, 32'h7, 32'h3);
		fire(2);
		chk(medium_b_out, 1'b1);
		chk(n_probe, 2);
		rd(REG_ERRORS, 32'h7, 32'h7);
		bus(1'b1, REG_ERRORS, 32'h7);
		rd(REG_ERRORS, 32'h7, 32'h0);
		cmd(4'h1, 1'b0);
		cmd(4'h4, 1'b0);
		rd(REG_STATUS, 32'h7, 32'h0);
		fire(0);
		chk(medium_b_out, 1'b0);
		chk(n_probe, 2);
		rd(REG_ERRORS, 32'h7, 32'h1);
		cmd(4'h8, 1'b0);
		cmd(4'h2, 1'b1);
		cmd(4'h1, 1'b0);
		cmd(4'h3, 1'b1);
		cmd(4'h1, 1'b0);
		arm(34);
		grant();
		grant();
		while (sync_q.size() != 0)
			@(posedge mclk_in);
		arm(3);
		while (sync_q.size() != 0)
			@(posedge mclk_in);
		repeat (SF / 2) @(posedge mclk_in);
		armed = 1'b0;
		chk(sdat_q.size(), 0);
		wrap_up();
	end
endmodule
